// ==== rtl/hsps_pkg.sv ====
package hsps_pkg;
  localparam int WB_AW      = 8;
  localparam int DIV_W      = 8;
  localparam int CLK_HZ     = 50_000_000;
  localparam int SPI_MAX_HZ = 2_500_000;
  localparam int I2C_MAX_HZ = 400_000;
  // Least half and quarter periods round up, so neither link runs above its limit
  localparam logic [DIV_W-1:0] SPI_HALF_CYC =
    DIV_W'((CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ));
  localparam logic [DIV_W-1:0] I2C_QTR_CYC =
    DIV_W'((CLK_HZ + 4 * I2C_MAX_HZ - 1) / (4 * I2C_MAX_HZ));

  localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [WB_AW-1:0] REG_ADDR   = 8'h04;
  localparam logic [WB_AW-1:0] REG_WDATA  = 8'h08;
  localparam logic [WB_AW-1:0] REG_RDATA  = 8'h0c;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h10;

  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_LEN_LSB = 2;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_SPI     = 1;
  localparam int STAT_NACK    = 2;
  localparam int STAT_LOCKED  = 3;

  localparam logic [1:0] OP_NONE   = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_SELECT = 2'h3;

  localparam logic [7:0]  I2C_WR_BYTE     = 8'h70;
  localparam logic [7:0]  I2C_RD_BYTE     = 8'h71;
  localparam logic [6:0]  SPI_CMD_UPPER   = 7'h00;
  localparam logic [15:0] SPI_SELECT_ADDR = 16'hebff;
  localparam logic [15:0] LOCK_ADDR       = 16'hec01;
  localparam int          LOCK_BIT        = 1;
  localparam logic [1:0]  SELECT_FRAMES   = 2'h3;
  localparam logic [5:0]  SPI_HDR_BITS    = 6'h18;
  localparam logic [3:0]  I2C_HDR_BYTES   = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_I2C_START, ST_I2C_BIT, ST_I2C_STOP,
    ST_SPI_LO, ST_SPI_HI, ST_SPI_GAP, ST_DONE
  } hsps_state_t;

  typedef struct packed {
    hsps_state_t st;
    logic [1:0]  q;
    logic [5:0]  bits;
    logic [3:0]  idx;
    logic [1:0]  frames;
    logic [1:0]  op;
    logic [2:0]  len;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [55:0] tx;
    logic [7:0]  shb;
    logic        port_spi;
    logic        locked;
    logic        nack;
    logic        sck_o;
    logic        sck_oe;
    logic        sdo_o;
    logic        sdo_oe;
    logic        ss_n;
    logic        ack;
    logic [31:0] dat;
  } hsps_host_t;

  localparam hsps_host_t HOST_RESET = '{
    st: ST_IDLE, q: 2'h0, bits: 6'h00, idx: 4'h0, frames: 2'h0, op: OP_NONE,
    len: 3'h1, addr: 16'h0000, wdata: 32'h0, rdata: 32'h0, tx: 56'h0, shb: 8'h00,
    port_spi: 1'b0, locked: 1'b0, nack: 1'b0, sck_o: 1'b0, sck_oe: 1'b0,
    sdo_o: 1'b0, sdo_oe: 1'b0, ss_n: 1'b1, ack: 1'b0, dat: 32'h0};
endpackage : hsps_pkg

// ==== rtl/hsps_sync.sv ====
module hsps_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  import hsps_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hsps_sync_t;

  hsps_sync_t r;
  hsps_sync_t n;

  always_comb begin
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;
endmodule : hsps_sync

// ==== rtl/hsps_tick.sv ====
module hsps_tick (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [hsps_pkg::DIV_W-1:0] lim_i,
  output logic                           tick_o
);
  import hsps_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } hsps_tick_t;

  hsps_tick_t r;
  hsps_tick_t n;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (r.cnt >= lim_i - 8'h01) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick_o = r.tick;
endmodule : hsps_tick

// ==== rtl/hsps_host.sv ====
// How it works
// RULE1: Device keeps capture port off after reset.
// RULE2: Select pin high keeps two-wire port.
// RULE3: Three select falls switch device to SPI.
// RULE4: Select falls made by three dummy writes.
// RULE5: Set lock bit to pin two-wire port.
// RULE6: Any lock register write pins SPI port.
// RULE7: Two-wire clock at most 400 kHz.
// RULE8: Two-wire pins only pulled low, never driven.
// RULE9: Write: start, 0x70, address, value, stop.
// RULE10: Device acknowledges every written byte.
// RULE11: Address and value sent MSB first.
// RULE12: Read first loads pointer with 0x70.
// RULE13: Repeated start, 0x71, master acknowledges bytes.
// RULE14: Last read byte not acknowledged, then stop.
// RULE15: Device is SPI slave on four pins.
// RULE16: Host changes MOSI on falling SCLK.
// RULE17: Host samples MISO on rising SCLK; the code samples it at the end of the high half, just before the fall.
// RULE18: SPI clock at most 2.5 MHz.
// RULE19: Device floats MISO when not sending.
// RULE20: Select held low for whole frame.
// RULE21: Command byte bit 0 gives read/write.
// RULE22: Write value follows address without gap.
// RULE23: Read value follows last address bit.
// RULE24: Device ignores foreign two-wire addresses.
// RULE25: Pointer kept across repeated start.
module hsps_host (
  input  wire logic                       CLOCK_I,
  input  wire logic                       RST_I,
  input  wire logic [hsps_pkg::WB_AW-1:0] ADR_I,
  input  wire logic [31:0]                DAT_I,
  input  wire logic                       WE_I,
  input  wire logic [3:0]                 SEL_I,
  input  wire logic                       CYC_I,
  input  wire logic                       STB_I,
  output logic      [31:0]                DAT_O,
  output logic                            ACK_O,
  input  wire logic                       SCL_SCLK_I,
  output logic                            SCL_SCLK_O,
  output logic                            SCL_SCLK_OE_O,
  input  wire logic                       SDA_MOSI_I,
  output logic                            SDA_MOSI_O,
  output logic                            SDA_MOSI_OE_O,
  input  wire logic                       MISO_I,
  output logic                            PORT_SELECT_PIN_O
);
  import hsps_pkg::*;

  hsps_host_t       r;
  hsps_host_t       n;
  logic [2:0]       pins_s;
  logic             scl_s;
  logic             sda_s;
  logic             miso_s;
  logic             tick;
  logic [DIV_W-1:0] lim;
  logic             wb_hit;
  logic             is_rd;
  logic             spi_st;
  logic [5:0]       spi_total;
  logic [3:0]       i2c_total;
  logic             i2c_rx;
  logic             i2c_last;
  logic [31:0]      status;
  logic [1:0]       ss_falls_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction : merge

  function automatic logic [2:0] len_of(input logic [1:0] code);
    len_of = (code == 2'h0) ? 3'h1 : (code == 2'h1) ? 3'h2 : 3'h4;
  endfunction : len_of

  // Command, address and value in one shift word, so no clock is lost
  function automatic logic [55:0] spi_frame(input logic rd, input logic [15:0] a,
                                            input logic [31:0] d, input logic [2:0] len);
    logic [5:0]  sh;
    logic [31:0] al;
    sh = {3'h4 - len, 3'h0};
    al = d << sh;
    spi_frame = {SPI_CMD_UPPER, rd, a, al}; // RULE21 RULE22
  endfunction : spi_frame

  function automatic logic [7:0] byte_at(input logic [3:0] idx, input logic rd,
                                         input logic [15:0] a, input logic [31:0] d,
                                         input logic [2:0] len);
    logic [2:0] k;
    logic [5:0] sh;
    k  = 3'(idx - I2C_HDR_BYTES);
    sh = {len - 3'h1 - k, 3'h0};
    if (idx == 4'h0) begin
      byte_at = I2C_WR_BYTE; // RULE9
    end else if (idx == 4'h1) begin
      byte_at = a[15:8]; // RULE11
    end else if (idx == 4'h2) begin
      byte_at = a[7:0];
    end else if (rd) begin
      byte_at = I2C_RD_BYTE; // RULE13
    end else begin
      byte_at = 8'(d >> sh);
    end
  endfunction : byte_at

  hsps_sync #(
    .W (3)
  ) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .d_i   ({SCL_SCLK_I, SDA_MOSI_I, MISO_I}),
    .q_o   (pins_s)
  );

  assign scl_s  = pins_s[2];
  assign sda_s  = pins_s[1];
  assign miso_s = pins_s[0];

  assign spi_st = (r.st == ST_SPI_LO) || (r.st == ST_SPI_HI) || (r.st == ST_SPI_GAP);
  assign lim    = spi_st ? SPI_HALF_CYC : I2C_QTR_CYC; // RULE7 RULE18

  hsps_tick u_tick (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .lim_i  (lim),
    .tick_o (tick)
  );

  assign wb_hit    = CYC_I && STB_I && !r.ack;
  assign is_rd     = (r.op == OP_READ);
  assign spi_total = SPI_HDR_BITS + {r.len, 3'h0};
  assign i2c_total = I2C_HDR_BYTES + {1'b0, r.len} + {3'h0, is_rd};
  assign i2c_rx    = is_rd && (r.idx > I2C_HDR_BYTES);
  assign i2c_last  = (r.idx == i2c_total - 4'h1);

  always_comb begin
    status              = '0;
    status[STAT_BUSY]   = (r.st != ST_IDLE);
    status[STAT_SPI]    = r.port_spi;
    status[STAT_NACK]   = r.nack;
    status[STAT_LOCKED] = r.locked;
  end

  always_comb begin
    n     = r;
    n.ack = wb_hit;
    if (wb_hit && !WE_I) begin
      case (ADR_I)
        REG_CTRL:   n.dat = {28'h0, r.len == 3'h4, r.len == 3'h2, r.op};
        REG_ADDR:   n.dat = {16'h0, r.addr};
        REG_WDATA:  n.dat = r.wdata;
        REG_RDATA:  n.dat = r.rdata;
        REG_STATUS: n.dat = status;
        default:    n.dat = 32'h0;
      endcase
    end
    if (wb_hit && WE_I && r.st == ST_IDLE) begin
      if (ADR_I == REG_ADDR) begin
        n.addr = 16'(merge({16'h0, r.addr}, DAT_I, SEL_I));
      end
      if (ADR_I == REG_WDATA) begin
        n.wdata = merge(r.wdata, DAT_I, SEL_I);
      end
      // A select after a two-wire lock would be ignored by the device anyway
      if (ADR_I == REG_CTRL && SEL_I[0] && DAT_I[CTRL_OP_LSB +: 2] != OP_NONE
          && !(DAT_I[CTRL_OP_LSB +: 2] == OP_SELECT && r.locked)) begin
        n.op     = DAT_I[CTRL_OP_LSB +: 2];
        n.len    = len_of(DAT_I[CTRL_LEN_LSB +: 2]);
        n.nack   = 1'b0;
        n.rdata  = 32'h0;
        n.frames = 2'h1;
        if (n.op == OP_SELECT) begin
          n.addr   = SPI_SELECT_ADDR; // RULE4
          n.len    = 3'h1;
          n.wdata  = 32'h0;
          n.frames = SELECT_FRAMES; // RULE3
        end
        if (n.op == OP_SELECT || r.port_spi) begin
          n.tx     = spi_frame(n.op == OP_READ, n.addr, n.wdata, n.len); // RULE15
          n.bits   = 6'h00;
          n.ss_n   = 1'b0; // RULE20
          n.sck_o  = 1'b1;
          n.sck_oe = 1'b1;
          n.sdo_oe = 1'b1;
          n.st     = ST_SPI_LO;
        end else begin
          n.idx = 4'h0;
          n.q   = 2'h0;
          n.st  = ST_I2C_START;
        end
      end
    end

    unique case (r.st)
      ST_IDLE: begin
      end
      ST_I2C_START: begin
        if (tick) begin
          n.q = r.q + 2'h1;
          unique case (r.q)
            2'h0: n.sck_oe = 1'b1;
            2'h1: n.sdo_oe = 1'b0;
            2'h2: n.sck_oe = 1'b0;
            2'h3: begin
              if (!scl_s) begin
                n.q = r.q;
              end else begin
                n.sdo_oe = 1'b1; // RULE13
                n.shb    = byte_at(r.idx, is_rd, r.addr, r.wdata, r.len);
                n.bits   = 6'h00;
                n.st     = ST_I2C_BIT;
              end
            end
          endcase
        end
      end
      ST_I2C_BIT: begin
        if (tick) begin
          n.q = r.q + 2'h1;
          unique case (r.q)
            2'h0: n.sck_oe = 1'b1; // RULE8
            2'h1: begin
              if (r.bits < 6'h08) begin
                n.sdo_oe = !i2c_rx && !r.shb[7]; // RULE11
              end else begin
                n.sdo_oe = i2c_rx && !i2c_last; // RULE13 RULE14
              end
            end
            2'h2: n.sck_oe = 1'b0;
            2'h3: begin
              if (!scl_s) begin
                n.q = r.q;
              end else if (r.bits < 6'h08) begin
                n.shb  = {r.shb[6:0], sda_s};
                n.bits = r.bits + 6'h01;
              end else begin
                if (i2c_rx) begin
                  n.rdata = {r.rdata[23:0], r.shb};
                end
                if (!i2c_rx && sda_s) begin
                  n.nack = 1'b1; // RULE10 RULE24
                  n.st   = ST_I2C_STOP;
                end else if (i2c_last) begin
                  n.st = ST_I2C_STOP;
                end else if (is_rd && r.idx == 4'h2) begin
                  // No stop here, the pointer must survive
                  n.idx = r.idx + 4'h1; // RULE25 RULE12
                  n.st  = ST_I2C_START;
                end else begin
                  n.idx  = r.idx + 4'h1;
                  n.shb  = byte_at(r.idx + 4'h1, is_rd, r.addr, r.wdata, r.len);
                  n.bits = 6'h00;
                end
              end
            end
          endcase
        end
      end
      ST_I2C_STOP: begin
        if (tick) begin
          n.q = r.q + 2'h1;
          unique case (r.q)
            2'h0: n.sck_oe = 1'b1;
            2'h1: n.sdo_oe = 1'b1;
            2'h2: n.sck_oe = 1'b0;
            2'h3: begin
              if (!scl_s) begin
                n.q = r.q;
              end else begin
                n.sdo_oe = 1'b0; // RULE14
                n.st     = ST_DONE;
              end
            end
          endcase
        end
      end
      ST_SPI_LO: begin
        if (tick) begin
          // Sampled at the end of the high half, just before the fall
          if (is_rd && r.bits > SPI_HDR_BITS) begin
            n.rdata = {r.rdata[30:0], miso_s}; // RULE17 RULE23
          end
          if (r.bits == spi_total) begin
            n.ss_n  = 1'b1;
            n.sck_o = 1'b1;
            n.st    = ST_SPI_GAP;
          end else begin
            n.sck_o = 1'b0;
            n.sdo_o = r.tx[55]; // RULE16
            n.tx    = r.tx << 1;
            n.st    = ST_SPI_HI;
          end
        end
      end
      ST_SPI_HI: begin
        if (tick) begin
          n.sck_o = 1'b1;
          n.bits  = r.bits + 6'h01;
          n.st    = ST_SPI_LO;
        end
      end
      ST_SPI_GAP: begin
        if (tick) begin
          if (r.frames > 2'h1) begin
            n.frames = r.frames - 2'h1;
            n.tx     = spi_frame(1'b0, r.addr, r.wdata, r.len); // RULE4
            n.bits   = 6'h00;
            n.ss_n   = 1'b0;
            n.st     = ST_SPI_LO;
          end else begin
            n.st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (r.op == OP_SELECT) begin
          n.port_spi = 1'b1; // RULE3
        end
        if (r.op == OP_WRITE && r.addr == LOCK_ADDR && !r.nack
            && (r.port_spi || r.wdata[LOCK_BIT])) begin
          n.locked = 1'b1; // RULE5 RULE6
        end
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= HOST_RESET;
    end else begin
      r <= n;
    end
  end

  // Select-pin falls seen by the device, for checking only
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ss_falls_q <= 2'h0;
    end else if (r.ss_n && !n.ss_n) begin
      ss_falls_q <= (r.st == ST_IDLE) ? 2'h1 : ss_falls_q + 2'h1;
    end else if (r.st == ST_IDLE) begin
      ss_falls_q <= 2'h0;
    end
  end

  // In two-wire use the lines only pull low, released they float high; SPI and select frames drive them both ways
  assign SCL_SCLK_O        = r.sck_o; // RULE8
  assign SCL_SCLK_OE_O     = r.sck_oe;
  assign SDA_MOSI_O        = r.sdo_o;
  assign SDA_MOSI_OE_O     = r.sdo_oe;
  assign PORT_SELECT_PIN_O = r.ss_n; // RULE2
  assign DAT_O             = r.dat;
  assign ACK_O             = r.ack;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  ss_i2c_high_a: assert property ( // RULE2
    !r.port_spi && r.op != OP_SELECT |-> r.ss_n)
    else $error("select pin low while two-wire port in use");

  select_three_a: assert property ( // RULE3
    r.st == ST_DONE && r.op == OP_SELECT |-> ss_falls_q == 2'h3 ##1 r.port_spi)
    else $error("port switched without three select falls");

  lock_cause_a: assert property ( // RULE5
    $rose(r.locked) |-> $past(r.addr) == LOCK_ADDR && $past(r.st) == ST_DONE)
    else $error("lock set without a lock register write");

  spi_lock_a: assert property ( // RULE6
    r.port_spi && r.st == ST_DONE && r.op == OP_WRITE && r.addr == LOCK_ADDR
    && !r.nack |=> r.locked)
    else $error("write to lock register did not lock SPI");

  i2c_open_a: assert property ( // RULE8
    !r.port_spi && (r.st == ST_I2C_BIT || r.st == ST_I2C_START) |-> !r.sck_o && !r.sdo_o)
    else $error("two-wire line driven high");

  i2c_first_a: assert property ( // RULE13
    $past(r.st) == ST_I2C_START && r.st == ST_I2C_BIT
    |-> r.shb == ((r.idx == 4'h0) ? I2C_WR_BYTE : I2C_RD_BYTE))
    else $error("wrong slave byte after start");

  i2c_nack_last_a: assert property ( // RULE14
    r.st == ST_I2C_BIT && r.bits == 6'h08 && r.q == 2'h2 && i2c_rx
    |-> r.sdo_oe == !i2c_last)
    else $error("acknowledge wrong on read byte");

  mosi_edge_a: assert property ( // RULE16
    !r.ss_n && $changed(r.sdo_o) |-> !r.sck_o && $fell(r.sck_o))
    else $error("MOSI changed away from a falling clock");

  spi_rate_a: assert property ( // RULE18
    $fell(r.sck_o) && spi_st |-> !r.sck_o [*8])
    else $error("SPI clock low half too short");

  spi_ss_low_a: assert property ( // RULE20
    r.st == ST_SPI_HI |-> !r.ss_n ##1 !r.ss_n)
    else $error("select raised inside a frame");

  spi_cmd_a: assert property ( // RULE21
    $fell(r.ss_n) |-> r.tx[55:49] == SPI_CMD_UPPER && r.tx[48] == is_rd)
    else $error("bad SPI command byte");

  wb_ack_a: assert property (
    ACK_O |=> !ACK_O)
    else $error("bus answer held two cycles");
endmodule : hsps_host

// ==== tb/hsps_dev.sv ====
module hsps_dev (
  input  wire logic rst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic ss_n_i,
  input  wire logic nak_i,
  output logic      sda_low_o,
  output logic      miso_o,
  output logic      spi_o,
  output logic      lock_o,
  output int        viol_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [15:0]];
  int          wid [logic [15:0]];
  logic [31:0] sh, tx, wv;
  logic [15:0] ptr;
  logic        act, ok, rd, drv;
  int          cnt, nb, fl;
  realtime     t_rise;

  // Short registers return left-aligned so the top byte goes first
  function automatic logic [31:0] rdv(input logic [15:0] a);
    if (!mem.exists(a)) return 32'h0;
    return mem[a] << (32 - wid[a]);
  endfunction : rdv

  // No capture port modelled: it stays off after reset
  always @(posedge rst_i or negedge rst_i) begin
    spi_o = 1'b0;
    lock_o = 1'b0;
    fl = 0;
    act = 1'b0;
    sda_low_o = 1'b0;
    drv = 1'b0;
    tx = 32'h0;
    t_rise = -1.0e9;
  end
  initial viol_o = 0;
  assign miso_o = tx[31];

  always @(negedge ss_n_i) begin
    if (!spi_o && !lock_o) begin
      fl++;
      if (fl == 3) spi_o = 1'b1;
    end
    cnt = 0;
    rd = 1'b0;
  end

  always @(posedge ss_n_i) begin
    if (spi_o && !rd && cnt > 24 && cnt % 8 == 0) begin
      if (ptr == 16'hec01) lock_o = 1'b1;
      else if (ptr != 16'hebff) begin
        mem[ptr] = sh;
        wid[ptr] = cnt - 24;
      end
    end
    // Released line shows the inverse of the last bit
    if (drv) tx = ~tx;
    drv = 1'b0;
  end

  always @(posedge scl_i) begin
    if (!ss_n_i && spi_o) begin
      if ($realtime - t_rise < 400) viol_o++;
      t_rise = $realtime;
      sh = {sh[30:0], sda_i};
      cnt++;
      if (cnt == 8) rd = sh[0];
      if (cnt == 24) begin
        ptr = sh[15:0];
        tx = rdv(ptr);
        sh = 32'h0;
      end
    end else if (ss_n_i && !spi_o && act) begin
      if ($realtime - t_rise < 2500) viol_o++;
      t_rise = $realtime;
      if (cnt < 8) begin
        sh = {sh[30:0], sda_i};
        cnt++;
        if (cnt == 8) begin
          if (nb == 0) begin
            ok = sh[7:1] == 7'h38 && !nak_i;
            rd = sh[0];
            if (rd) tx = rdv(ptr);
          end else if (!rd && nb == 1) ptr[15:8] = sh[7:0];
          else if (!rd && nb == 2) ptr[7:0] = sh[7:0];
          else if (!rd) wv = {wv[23:0], sh[7:0]};
          nb++;
        end
      end else begin
        cnt = 0;
        if (rd && nb > 1 && sda_i) act = 1'b0;
      end
    end
  end

  always @(negedge scl_i) begin
    if (!ss_n_i && spi_o) begin
      if (rd && cnt >= 24) begin
        if (drv) tx = tx << 1;
        drv = 1'b1;
      end
    end else if (ss_n_i && !spi_o) begin
      // Open drain: the model only ever pulls low
      if (!act || !ok) sda_low_o = 1'b0;
      else if (cnt == 8) sda_low_o = !rd || nb == 1;
      // Data starts right after the acknowledged read address byte
      else if (rd && nb > 0) begin
        sda_low_o = !tx[31];
        tx = tx << 1;
      end else sda_low_o = 1'b0;
    end
  end

  always @(negedge sda_i) begin
    if (scl_i && ss_n_i && !spi_o) begin
      act = 1'b1;
      cnt = 0;
      nb = 0;
      wv = 32'h0;
    end
  end

  always @(posedge sda_i) begin
    if (scl_i && ss_n_i && !spi_o && act && !rd && ok && nb > 3) begin
      if (ptr == 16'hec01) lock_o = lock_o | wv[1];
      else begin
        mem[ptr] = wv;
        wid[ptr] = (nb - 3) * 8;
      end
    end
    if (scl_i && ss_n_i) act = 1'b0;
  end
endmodule : hsps_dev

// ==== tb/hsps_host_bench.sv ====
module hsps_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import hsps_pkg::*;
  logic        clk, rst, we, cyc, stb, ack, nak;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic        scl_o, scl_oe, sda_o, sda_oe, ss, miso, dev_low, spi, lock;
  int          viol, error_cnt, num_checks;
  // Pull-ups on both two-wire lines
  wire         scl = scl_oe ? scl_o : 1'b1;
  wire         sda = (sda_oe ? sda_o : 1'b1) & ~dev_low;

  hsps_host uut (.CLOCK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(wdat), .WE_I(we),
    .SEL_I(4'hf), .CYC_I(cyc), .STB_I(stb), .DAT_O(rdat), .ACK_O(ack),
    .SCL_SCLK_I(scl), .SCL_SCLK_O(scl_o), .SCL_SCLK_OE_O(scl_oe), .SDA_MOSI_I(sda),
    .SDA_MOSI_O(sda_o), .SDA_MOSI_OE_O(sda_oe), .MISO_I(miso), .PORT_SELECT_PIN_O(ss));
  hsps_dev u_dev (.rst_i(rst), .scl_i(scl), .sda_i(sda), .ss_n_i(ss), .nak_i(nak),
    .sda_low_o(dev_low), .miso_o(miso), .spi_o(spi), .lock_o(lock), .viol_o(viol));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk("wb_ack", 1'b0, 1'b1);
  endtask : wb

  // Returns STATUS once busy has cleared
  task automatic op(input logic [1:0] o, input logic [1:0] ln, input logic [15:0] a,
                    input logic [31:0] d, output logic [31:0] st);
    int n;
    wb(1'b1, REG_ADDR, {16'h0, a}, st);
    wb(1'b1, REG_WDATA, d, st);
    wb(1'b1, REG_CTRL, {28'h0, ln, o}, st);
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, st);
      n++;
    end while (st[STAT_BUSY] !== 1'b0 && n < 20000);
    if (n >= 20000) chk("busy", 1'b1, 1'b0);
  endtask : op

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic t_reset();
    logic [31:0] r;
    chk("select_pin", ss, 1'b1);
    wb(1'b0, REG_STATUS, 32'h0, r);
    chk("status", r, 32'h0);
    wb(1'b0, 8'h20, 32'h0, r);
    chk("unmapped", r, 32'h0);
  endtask : t_reset

  task automatic t_i2c();
    logic [31:0] r;
    op(OP_WRITE, 2'h2, 16'h1234, 32'hdeadbeef, r);
    chk("i2c_nack", r[STAT_NACK], 1'b0);
    chk("i2c_mem", u_dev.mem[16'h1234], 32'hdeadbeef);
    op(OP_READ, 2'h2, 16'h1234, 32'h0, r);
    wb(1'b0, REG_RDATA, 32'h0, r);
    chk("i2c_rd", r, 32'hdeadbeef);
    wb(1'b0, REG_CTRL, 32'h0, r);
    chk("ctrl_rb", r, 32'h0000000a);
    wb(1'b0, REG_ADDR, 32'h0, r);
    chk("addr_rb", r, 32'h00001234);
    nak <= 1'b1;
    op(OP_WRITE, 2'h0, 16'h0055, 32'h11, r);
    nak <= 1'b0;
    chk("nak_flag", r[STAT_NACK], 1'b1);
    chk("nak_mem", u_dev.mem.exists(16'h0055), 1'b0);
  endtask : t_i2c

  task automatic t_i2c_lock();
    logic [31:0] r;
    op(OP_WRITE, 2'h0, LOCK_ADDR, 32'h2, r);
    chk("i2c_locked", r[STAT_LOCKED], 1'b1);
    chk("dev_lock", lock, 1'b1);
    op(OP_SELECT, 2'h0, 16'h0, 32'h0, r);
    chk("still_i2c", r[STAT_SPI], 1'b0);
    chk("dev_i2c", spi, 1'b0);
  endtask : t_i2c_lock

  task automatic t_spi();
    logic [31:0] r;
    op(OP_SELECT, 2'h0, 16'h0, 32'h0, r);
    chk("spi_stat", r[STAT_SPI], 1'b1);
    chk("dev_spi", spi, 1'b1);
    chk("falls", u_dev.fl, 3);
    wb(1'b0, REG_ADDR, 32'h0, r);
    chk("sel_addr", r, {16'h0, SPI_SELECT_ADDR});
    op(OP_WRITE, 2'h2, 16'h0100, 32'ha5c30f96, r);
    chk("spi_mem", u_dev.mem[16'h0100], 32'ha5c30f96);
    op(OP_WRITE, 2'h1, 16'h0102, 32'h0000beef, r);
    chk("spi_mem16", u_dev.mem[16'h0102], 32'h0000beef);
    wb(1'b0, REG_WDATA, 32'h0, r);
    chk("wdata_rb", r, 32'h0000beef);
    op(OP_READ, 2'h2, 16'h0100, 32'h0, r);
    wb(1'b0, REG_RDATA, 32'h0, r);
    chk("spi_rd", r, 32'ha5c30f96);
    op(OP_READ, 2'h1, 16'h0102, 32'h0, r);
    wb(1'b0, REG_RDATA, 32'h0, r);
    chk("spi_rd16", r, 32'h0000beef);
    op(OP_WRITE, 2'h0, LOCK_ADDR, 32'h0, r);
    chk("spi_locked", r[STAT_LOCKED], 1'b1);
    chk("dev_lock", lock, 1'b1);
  endtask : t_spi

  initial begin
    #1_500_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    nak = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    do_reset();
    t_reset();
    t_i2c();
    t_i2c_lock();
    do_reset();
    t_reset();
    t_spi();
    chk("link_rate", viol, 0);
    print_verdict();
  end
endmodule : hsps_host_bench
